/* include/boe_pkg.sv */
// Package with encodings and constants for the byte-op instruction executor
package boe_pkg;
  // ------------------------------------------------------------
  // Opcode prefixes
  // ------------------------------------------------------------
  localparam logic [6:0] NEG_PREFIX  = 7'h36;  // 0110 110a
  localparam logic [5:0] SUBB_PREFIX = 6'h16;  // 0101 10da
  localparam logic [5:0] SWAP_PREFIX = 6'h0E;  // 0011 10da
  localparam logic [5:0] INC_PREFIX  = 6'h0A;  // 0010 10da
  localparam logic [3:0] BR1_PREFIX  = 4'hE;
  localparam logic [3:0] BR2_PREFIX  = 4'hF;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int DEST_BIT = 9;
  localparam int BANK_BIT = 8;
  // ------------------------------------------------------------
  // Addressing, reset values and last quarter
  // ------------------------------------------------------------
  localparam logic [7:0]  INDEX_LIMIT  = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hF;
  localparam logic [20:0] PC_RESET     = 21'h000000;
  localparam logic [7:0]  WREG_RESET   = 8'h00;
  localparam logic [4:0]  FLAGS_RESET  = 5'h00;
  localparam logic [1:0]  Q_LAST       = 2'h3;
  // Flag positions: N, OV, Z, DC, C
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;

  typedef enum logic [2:0] {
    BOE_OP_IDLE = 3'b000,
    BOE_OP_NEG  = 3'b001,
    BOE_OP_SUBB = 3'b010,
    BOE_OP_SWAP = 3'b011,
    BOE_OP_INC  = 3'b100,
    BOE_OP_BR   = 3'b101
  } boe_op_t;
endpackage

/* verilog/boe_exec.sv */
// Decode and execute core for a subset of byte-oriented instructions
//
// Functional notes
// - Negate replaces file with two's complement, flags
// - Negate always writes back to file
// - Subtract: file minus W minus inverted carry
// - Dest bit 0 selects W, 1 file
// - Bank bit 0 access bank, 1 bank select
// - Access, extended, f<=95: indexed literal offset
// - Nibble swap into destination, flags unchanged
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module boe_exec (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ext_set_en,
  input  wire logic [15:0] instr_word,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  mem_rdata,
  output logic      [11:0] mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic      [7:0]  mem_wdata,
  output logic             fetch_next,
  output logic      [20:0] pc,
  output logic      [7:0]  wreg,
  output logic      [4:0]  flags,
  output logic      [1:0]  quarter
);
  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [1:0]  next_quarter;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic        br_second;
  logic        next_br_second;
  logic [7:0]  br_lit;
  logic [7:0]  next_br_lit;
  logic [7:0]  operand;
  logic [7:0]  next_operand;
  logic [7:0]  result;
  logic [7:0]  next_result;
  logic [4:0]  next_flags;
  logic [7:0]  next_wreg;
  logic [20:0] next_pc;
  logic [11:0] next_mem_addr;
  logic        next_mem_wr;
  logic [7:0]  next_mem_wdata;
  boe_pkg::boe_op_t op;

  function automatic boe_pkg::boe_op_t decode(input logic [15:0] w);
    if (w[15:9] == boe_pkg::NEG_PREFIX)
      return boe_pkg::BOE_OP_NEG;
    else if (w[15:10] == boe_pkg::SUBB_PREFIX)
      return boe_pkg::BOE_OP_SUBB;
    else if (w[15:10] == boe_pkg::SWAP_PREFIX)
      return boe_pkg::BOE_OP_SWAP;
    else if (w[15:10] == boe_pkg::INC_PREFIX)
      return boe_pkg::BOE_OP_INC;
    else if (w[15:12] == boe_pkg::BR1_PREFIX)
      return boe_pkg::BOE_OP_BR;
    else
      return boe_pkg::BOE_OP_IDLE;
  endfunction

  // Adds a + b + cin, returns {carry, digit carry, overflow, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [8:0] s;
    logic [4:0] lo;
    logic       ov;
    s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    ov = (a[7] == b[7]) && (s[7] != a[7]);
    return {s[8], lo[4], ov, s[7:0]};
  endfunction

  // Arithmetic flags from an add8 result
  function automatic logic [4:0] arith_flags(input logic [10:0] r);
    logic [4:0] f;
    f = 5'h00;
    f[boe_pkg::FLAG_C]  = r[10];
    f[boe_pkg::FLAG_DC] = r[9];
    f[boe_pkg::FLAG_OV] = r[8];
    f[boe_pkg::FLAG_N]  = r[7];
    f[boe_pkg::FLAG_Z]  = (r[7:0] == 8'h00);
    return f;
  endfunction

  // Operand address: access bank, indexed, or banked
  function automatic logic [11:0] file_addr(input logic [7:0] f, input logic a,
                                            input logic ext, input logic [3:0] bank_sel,
                                            input logic [11:0] base);
    if (a)
      return {bank_sel, f};
    else if (ext && (f <= boe_pkg::INDEX_LIMIT))
      return 12'(base + {4'h0, f});
    else if (f < boe_pkg::ACCESS_SPLIT)
      return {4'h0, f};
    else
      return {boe_pkg::ACCESS_HIGH, f};
  endfunction

  assign op = br_second ? boe_pkg::BOE_OP_IDLE : decode(ir);

  // ------------------------------------------------------------
  // Quarter sequencing and execution
  // ------------------------------------------------------------
  always_comb begin
    logic [10:0] ar;
    ar             = 11'h000;
    next_quarter   = 2'(quarter + 2'h1);
    next_ir        = ir;
    next_br_second = br_second;
    next_br_lit    = br_lit;
    next_operand   = operand;
    next_result    = result;
    next_flags     = flags;
    next_wreg      = wreg;
    next_pc        = pc;
    next_mem_addr  = mem_addr;
    next_mem_wr    = 1'b0;
    next_mem_wdata = mem_wdata;
    unique case (quarter)
      2'h0: begin
        // Decode; address is formed here so data is ready in Q2
        next_mem_addr = file_addr(ir[7:0], ir[boe_pkg::BANK_BIT], ext_set_en,
                                  bank_select_reg, index_base);
      end
      2'h1: begin
        next_operand = mem_rdata;
      end
      2'h2: begin
        unique case (op)
          boe_pkg::BOE_OP_NEG: begin
            ar          = add8(~operand, 8'h00, 1'b1);
            next_result = ar[7:0];
            next_flags  = arith_flags(ar);
          end
          boe_pkg::BOE_OP_SUBB: begin
            ar          = add8(operand, ~wreg, flags[boe_pkg::FLAG_C]);
            next_result = ar[7:0];
            next_flags  = arith_flags(ar);
          end
          boe_pkg::BOE_OP_INC: begin
            ar          = add8(operand, 8'h01, 1'b0);
            next_result = ar[7:0];
            next_flags  = arith_flags(ar);
          end
          boe_pkg::BOE_OP_SWAP: begin
            next_result = {operand[3:0], operand[7:4]};
          end
          default: begin
            next_result = result;
          end
        endcase
      end
      2'h3: begin
        next_pc = 21'(pc + 21'h2);
        unique case (op)
          boe_pkg::BOE_OP_NEG: begin
            next_mem_wr    = 1'b1;
            next_mem_wdata = result;
          end
          boe_pkg::BOE_OP_SUBB, boe_pkg::BOE_OP_SWAP, boe_pkg::BOE_OP_INC: begin
            if (ir[boe_pkg::DEST_BIT]) begin
              next_mem_wr    = 1'b1;
              next_mem_wdata = result;
            end else begin
              next_wreg = result;
            end
          end
          boe_pkg::BOE_OP_BR: begin
            // Low literal is kept aside since ir now takes the second word
            next_br_second = 1'b1;
            next_br_lit    = ir[7:0];
          end
          default: begin
            // Second word of a branch lands here: its literal completes the jump
            if (br_second) begin
              next_pc        = {ir[11:0], br_lit, 1'b0};
              next_br_second = 1'b0;
            end
          end
        endcase
        // A branch second word is fetched like any word but only read for its literal
        next_ir = instr_word;
      end
      default: begin
        next_quarter = 2'h0;
      end
    endcase
  end

  // Word taken from memory at the end of each cycle
  assign fetch_next = (quarter == boe_pkg::Q_LAST);
  assign mem_rd     = (quarter == 2'h1) && (op != boe_pkg::BOE_OP_IDLE)
                      && (op != boe_pkg::BOE_OP_BR);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quarter   <= 2'h0;
      ir        <= 16'h0000;
      br_second <= 1'b0;
      br_lit    <= 8'h00;
      operand   <= 8'h00;
      result    <= 8'h00;
      flags     <= boe_pkg::FLAGS_RESET;
      wreg      <= boe_pkg::WREG_RESET;
      pc        <= boe_pkg::PC_RESET;
      mem_addr  <= 12'h000;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else begin
      quarter   <= next_quarter;
      ir        <= next_ir;
      br_second <= next_br_second;
      br_lit    <= next_br_lit;
      operand   <= next_operand;
      result    <= next_result;
      flags     <= next_flags;
      wreg      <= next_wreg;
      pc        <= next_pc;
      mem_addr  <= next_mem_addr;
      mem_wr    <= next_mem_wr;
      mem_wdata <= next_mem_wdata;
    end
  end
endmodule

/* testbench/boe_mem_model.sv */
// Data memory partner model seen by the executor
`timescale 1ns/1ps
module boe_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:4095];
  logic [7:0] last = 8'h00;
  // Plain always so the bench may preload the array
  always @(posedge clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) last <= mem[mem_addr];
  end
  // Idle bus shows inverted old data, never a stale match
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
endmodule

/* testbench/boe_exec_checker.sv */
// Timing and addressing checker for the executor ports
`timescale 1ns/1ps
module boe_exec_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ext_set_en,
  input wire logic [15:0] instr_word,
  input wire logic [3:0]  bank_select_reg,
  input wire logic [11:0] index_base,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [20:0] pc,
  input wire logic [4:0]  flags,
  input wire logic        fetch_next,
  input wire logic [1:0]  quarter
);
  logic [15:0] ir;
  logic        dsel;
  logic        bop;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ir <= 16'h0000;
    else if (quarter == 2'h3) ir <= instr_word;
  end
  assign dsel = ir[9];
  assign bop  = ir[15:10] inside {boe_pkg::SUBB_PREFIX, boe_pkg::SWAP_PREFIX, boe_pkg::INC_PREFIX};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_quarter_step: assert property (resetn |=> quarter == $past(quarter) + 2'h1)
    else $error("quarter did not advance");
  a_fetch_q4: assert property (fetch_next == (quarter == 2'h3))
    else $error("fetch outside last quarter");
  a_read_q2: assert property (mem_rd |-> quarter == 2'h1)
    else $error("read outside second quarter");
  a_write_pulse: assert property (mem_wr |-> quarter == 2'h0 ##1 !mem_wr)
    else $error("write pulse misplaced");
  a_neg_to_file: assert property (quarter == 2'h3 && ir[15:9] == boe_pkg::NEG_PREFIX |=> mem_wr)
    else $error("negate did not write file");
  a_dest_select: assert property (quarter == 2'h3 && bop |=> mem_wr == $past(dsel))
    else $error("destination select ignored");
  a_nop_quiet: assert property (quarter == 2'h0 && (ir == 16'h0000 || ir[15:12] == 4'hF)
    |=> !mem_rd ##3 !mem_wr)
    else $error("no-op touched memory");
  a_bank_addr: assert property (mem_rd && ir[8] |-> mem_addr == {bank_select_reg, ir[7:0]})
    else $error("banked address wrong");
  a_access_addr: assert property (mem_rd && !ir[8] && !(ext_set_en && ir[7:0] <= 8'h5F)
    |-> mem_addr == {ir[7] ? 4'hF : 4'h0, ir[7:0]})
    else $error("access bank address wrong");
  a_index_addr: assert property (mem_rd && !ir[8] && ext_set_en && ir[7:0] <= 8'h5F
    |-> mem_addr == index_base + {4'h0, ir[7:0]})
    else $error("indexed address wrong");
  a_swap_flags: assert property (quarter == 2'h0 && ir[15:10] == boe_pkg::SWAP_PREFIX
    |=> $stable(flags)[*4])
    else $error("swap changed flags");
  a_pc_even: assert property (pc[0] == 1'b0)
    else $error("pc bit zero set");
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the byte-op instruction executor
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0, resetn = 1'b0, ext_set_en = 1'b0, mem_rd, mem_wr, fetch_next;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [11:0] index_base = 12'h000, mem_addr;
  logic [7:0]  mem_rdata, mem_wdata, wreg, rw = 8'h00;
  logic [20:0] pc;
  logic [4:0]  flags, rf = 5'h00;
  logic [1:0]  quarter;
  logic [7:0]  rmem [0:4095];
  int          n_fail = 0, total_checks = 0, cycles = 0;
  boe_exec i_boe_exec (
    .clk             (clk),
    .resetn          (resetn),
    .ext_set_en      (ext_set_en),
    .instr_word      (instr_word),
    .bank_select_reg (bank_select_reg),
    .index_base      (index_base),
    .mem_rdata       (mem_rdata),
    .mem_addr        (mem_addr),
    .mem_rd          (mem_rd),
    .mem_wr          (mem_wr),
    .mem_wdata       (mem_wdata),
    .fetch_next      (fetch_next),
    .pc              (pc),
    .wreg            (wreg),
    .flags           (flags),
    .quarter         (quarter)
  );
  boe_mem_model i_boe_mem_model (
    .clk       (clk),
    .mem_rd    (mem_rd),
    .mem_wr    (mem_wr),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_rdata (mem_rdata)
  );
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin n_fail++; close_out(); end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [20:0] exp, logic [20:0] got);
    total_checks++;
    if (got !== exp) begin n_fail++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end
  endtask
  // Result {value, N, OV, Z, DC, C} of an 8-bit add with carry in
  function automatic logic [12:0] add(logic [7:0] a, logic [7:0] b, logic ci);
    logic [8:0] r;
    r = a + b + ci;
    add = {r[7:0], r[7], (a[7] == b[7]) && (r[7] != a[7]), r[7:0] == 8'h00,
           (a[3:0] + b[3:0] + ci) > 5'h0F, r[8]};
  endfunction
  task automatic issue(logic [15:0] w);
    do @(negedge clk); while (quarter !== 2'h2);
    @(posedge clk) instr_word <= w;
  endtask
  task automatic step(int op);
    logic [31:0] rn;
    logic [15:0] w;
    logic [11:0] ad;
    logic [12:0] r;
    rn = $urandom;
    ad = rn[8] ? {rn[23:20], rn[7:0]} : (rn[10] && rn[7:0] <= boe_pkg::INDEX_LIMIT)
         ? rn[31:20] + {4'h0, rn[7:0]} : {{4{rn[7]}}, rn[7:0]};
    case (op)
      0: w = {boe_pkg::NEG_PREFIX, rn[8:0]};
      1: w = {boe_pkg::SUBB_PREFIX, rn[9:0]};
      2: w = {boe_pkg::SWAP_PREFIX, rn[9:0]};
      3: w = {boe_pkg::INC_PREFIX, rn[9:0]};
      4: w = rn[11] ? 16'h0000 : {4'hF, rn[11:0]};
      default: w = {8'hEF, rn[19:12]};
    endcase
    r = (op == 1) ? add(rmem[ad], ~rw, rf[0]) : (op == 2) ? {rmem[ad][3:0], rmem[ad][7:4], rf}
        : add((op == 0) ? ~rmem[ad] : rmem[ad], 8'h00, 1'b1);
    if (op < 4) begin
      if (op == 0 || rn[9]) rmem[ad] = r[12:5];
      else rw = r[12:5];
      rf = r[4:0];
    end
    do @(negedge clk); while (quarter !== 2'h2);
    @(posedge clk);
    instr_word      <= w;
    ext_set_en      <= rn[10];
    bank_select_reg <= rn[23:20];
    index_base      <= rn[31:20];
    if (op == 5) issue({4'hF, rn[31:20]});
    issue(16'h0000);
    do @(negedge clk); while (quarter !== 2'h2);
    chk("wreg", rw, wreg);
    chk("flags", rf, flags);
    chk("file", rmem[ad], i_boe_mem_model.mem[ad]);
    if (op == 5) chk("pc", {rn[31:12], 1'b0}, pc);
  endtask
  initial begin
    void'($urandom(32'hBD2221B0));
    for (int i = 0; i < 4096; i++) begin
      rmem[i] = 8'($urandom);
      i_boe_mem_model.mem[i] = rmem[i];
    end
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // Every operation twice first, then a random mix
    for (int i = 0; i < 600; i++) step(i < 12 ? i % 6 : int'($urandom_range(5, 0)));
    close_out();
  end
endmodule

bind boe_exec boe_exec_checker i_boe_exec_checker (
  .clk             (clk),
  .resetn          (resetn),
  .ext_set_en      (ext_set_en),
  .instr_word      (instr_word),
  .bank_select_reg (bank_select_reg),
  .index_base      (index_base),
  .mem_addr        (mem_addr),
  .mem_rd          (mem_rd),
  .mem_wr          (mem_wr),
  .pc              (pc),
  .flags           (flags),
  .fetch_next      (fetch_next),
  .quarter         (quarter)
);
